// *** status_indicator.sv ***
// status indicator and output condition logic with apb registers
`timescale 1ns/1ps
`default_nettype none
module status_indicator
	import status_pkg::*;
#(
	parameter int blink_half_cycles = blink_half_cyc,
	parameter int link_hold_cycles  = link_hold_cyc
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// video and reference status
	input  wire video_status_t vstat,
	input  wire logic        sync_fitted,
	input  wire logic        link_event,
	// indicators and output condition
	output leds_t            leds,
	output out_cond_t        out_cond,
	output logic             irq
);

	// ====================================================================
	// register file
	logic [5:0]          ctrl_r;
	logic [ev_width-1:0] irq_stat_r;
	logic [ev_width-1:0] irq_mask_r;
	logic                wr_en;
	logic                rd_en;
	logic                mapped;

	assign mapped  = (paddr == ctrl_off) || (paddr == state_off) ||
	                 (paddr == irq_stat_off) || (paddr == irq_mask_off);
	assign wr_en   = psel && penable && pwrite && mapped;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= ctrl_reset_val;
		end else if (wr_en && paddr == ctrl_off) begin
			ctrl_r <= pwdata[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= '0;
		end else if (wr_en && paddr == irq_mask_off) begin
			irq_mask_r <= pwdata[ev_width-1:0];
		end
	end

	logic auto_sel;
	logic manual_625;
	logic delay_mode;
	logic autofreeze;
	logic init_busy;
	assign auto_sel   = ctrl_r[ctrl_auto_bit];
	assign manual_625 = ctrl_r[ctrl_manual_bit];
	assign delay_mode = ctrl_r[ctrl_delay_bit];
	assign autofreeze = ctrl_r[ctrl_freeze_bit];
	assign init_busy  = ctrl_r[ctrl_init_bit];

	// ====================================================================
	// shared blink timer
	logic [31:0] blink_cnt_r;
	logic        blink_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_r <= '0;
			blink_r     <= 1'b0;
		end else if (blink_cnt_r == 32'(blink_half_cycles - 1)) begin
			blink_cnt_r <= '0;
			blink_r     <= ~blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 32'h1;
		end
	end

	// link activity stretcher so short bursts stay visible
	logic [31:0] link_cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_cnt_r <= '0;
		end else if (link_event) begin
			link_cnt_r <= 32'(link_hold_cycles);
		end else if (link_cnt_r != 32'h0) begin
			link_cnt_r <= link_cnt_r - 32'h1;
		end
	end

	// ====================================================================
	// condition decode
	logic video_ok;
	logic std_mismatch;
	logic ref_missing;
	logic ref_bad;
	logic fault_now;

	assign video_ok     = vstat.sdi_present && vstat.sdi_valid;
	assign std_mismatch = !auto_sel && video_ok && (vstat.is_625 != manual_625);
	assign ref_missing  = sync_fitted && !delay_mode && !vstat.ref_present;
	assign ref_bad      = sync_fitted && !delay_mode && vstat.ref_present &&
	                      !vstat.ref_valid;

	out_cond_t   cond_nxt;
	leds_t       leds_nxt;

	always_comb begin
		cond_nxt  = out_correct_locked;
		fault_now = 1'b0;
		leds_nxt  = '0;
		leds_nxt.power_good     = 1'b1;
		leds_nxt.setup_activity = init_busy;
		leds_nxt.mode_auto      = auto_sel;
		leds_nxt.filter         = ctrl_r[ctrl_filter_bit] && video_ok;
		leds_nxt.link_activity  = link_cnt_r != 32'h0;
		if (!vstat.sdi_present) begin
			fault_now = 1'b1;
			leds_nxt.fault = blink_r;
			if (!sync_fitted) begin
				cond_nxt = out_none;
			end else if (autofreeze) begin
				cond_nxt = out_frozen;
			end else begin
				cond_nxt = out_corrupted;
			end
		end else if (!vstat.sdi_valid) begin
			fault_now = 1'b1;
			leds_nxt.fault = blink_r;
			// invalid video corrupts the output with or without the sync option
			cond_nxt = out_corrupted;
		end else if (std_mismatch) begin
			fault_now = 1'b1;
			leds_nxt.fault   = blink_r;
			leds_nxt.std_525 = !manual_625 && blink_r;
			leds_nxt.std_625 = manual_625 && blink_r;
			cond_nxt = out_corrupted;
		end else if (vstat.edh_error) begin
			fault_now = 1'b1;
			leds_nxt.fault   = blink_r;
			leds_nxt.std_525 = !vstat.is_625;
			leds_nxt.std_625 = vstat.is_625;
			cond_nxt = out_errors;
		end else if (ref_missing) begin
			fault_now = 1'b1;
			leds_nxt.fault   = blink_r;
			leds_nxt.std_525 = !vstat.is_625 && blink_r;
			leds_nxt.std_625 = vstat.is_625 && blink_r;
			cond_nxt = out_correct_free;
		end else if (ref_bad) begin
			fault_now = 1'b1;
			leds_nxt.fault   = blink_r;
			leds_nxt.std_525 = !vstat.is_625 && blink_r;
			leds_nxt.std_625 = vstat.is_625 && blink_r;
			cond_nxt = out_corrupted;
		end else begin
			leds_nxt.std_525 = !vstat.is_625;
			leds_nxt.std_625 = vstat.is_625;
			cond_nxt = (sync_fitted && !delay_mode) ? out_correct_locked
			                                         : out_correct_free;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			leds     <= '0;
			out_cond <= out_none;
		end else begin
			leds     <= leds_nxt;
			out_cond <= cond_nxt;
		end
	end

	// ====================================================================
	// interrupts: fault rise, standard change, output condition change
	logic                fault_d_r;
	logic                std_d_r;
	out_cond_t           cond_d_r;
	logic [ev_width-1:0] ev;
	logic                stat_rd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_d_r <= 1'b0;
			std_d_r   <= 1'b0;
			cond_d_r  <= out_none;
		end else begin
			fault_d_r <= fault_now;
			std_d_r   <= vstat.is_625;
			cond_d_r  <= cond_nxt;
		end
	end

	always_comb begin
		ev               = '0;
		ev[ev_fault_bit] = fault_now && !fault_d_r;
		ev[ev_std_bit]   = vstat.is_625 != std_d_r;
		ev[ev_out_bit]   = cond_nxt != cond_d_r;
	end

	assign stat_rd = rd_en && paddr == irq_stat_off;

	// set wins over the read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (stat_rd ? '0 : irq_stat_r) | ev;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// ====================================================================
	// read data
	always_comb begin
		prdata = 32'h0;
		if (rd_en) begin
			unique case (paddr)
				ctrl_off:     prdata = {26'h0, ctrl_r};
				state_off:    prdata = {21'h0, out_cond, leds};
				irq_stat_off: prdata = {29'h0, irq_stat_r};
				irq_mask_off: prdata = {29'h0, irq_mask_r};
				default:      prdata = 32'h0;
			endcase
		end
	end

endmodule
`default_nettype wire

// *** status_indicator_sva.sv ***
// checker for status indicator outputs
`timescale 1ns/1ps
`default_nettype none
module status_indicator_sva
	import status_pkg::*;
(
	// watched ports
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic [11:0]   paddr,
	input wire logic          pslverr,
	input wire video_status_t vstat,
	input wire logic          sync_fitted,
	input wire leds_t         leds,
	input wire out_cond_t     out_cond
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_absent_std_dark: assert property (!vstat.sdi_present |=> !leds.std_525 && !leds.std_625)
		else $error("standard lit without input");
	chk_lost_video_out: assert property (sync_fitted && !vstat.sdi_present
		|=> out_cond inside {out_corrupted, out_frozen})
		else $error("lost video gives wrong output");
	chk_no_sync_none: assert property (!sync_fitted && !vstat.sdi_present |=> out_cond == out_none)
		else $error("no output expected");
	chk_locked_fault_dark: assert property (out_cond == out_correct_locked |-> !leds.fault)
		else $error("fault lit in normal operation");
	chk_locked_ref_ok: assert property (out_cond == out_correct_locked
		|-> $past(sync_fitted && vstat.sdi_valid && vstat.ref_valid))
		else $error("locked without valid reference");
	chk_free_video_ok: assert property (out_cond == out_correct_free
		|-> $past(vstat.sdi_present && vstat.sdi_valid))
		else $error("free timing without valid video");
	chk_one_std: assert property (!(leds.std_525 && leds.std_625))
		else $error("both standards lit");
	chk_power_lit: assert property ($past(presetn) |-> leds.power_good)
		else $error("power indicator dark");
	chk_unmapped_err: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
		else $error("unmapped access not refused");
endmodule
bind status_indicator status_indicator_sva chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pslverr(pslverr), .vstat(vstat),
	.sync_fitted(sync_fitted), .leds(leds), .out_cond(out_cond));
`default_nettype wire

// *** status_pkg.sv ***
// status indicator package: constants and types
package status_pkg;

	// ====================================================================
	// register map (byte addresses)
	localparam logic [11:0] ctrl_off     = 12'h000;
	localparam logic [11:0] state_off    = 12'h004;
	localparam logic [11:0] irq_stat_off = 12'h008;
	localparam logic [11:0] irq_mask_off = 12'h00c;

	// control fields
	localparam int ctrl_auto_bit   = 0;
	localparam int ctrl_manual_bit = 1; // 0: 525, 1: 625
	localparam int ctrl_delay_bit  = 2;
	localparam int ctrl_freeze_bit = 3;
	localparam int ctrl_filter_bit = 4;
	localparam int ctrl_init_bit   = 5; // software clears when setup is done
	localparam logic [5:0] ctrl_reset_val = 6'h21;

	// interrupt event bits
	localparam int ev_fault_bit = 0;
	localparam int ev_std_bit   = 1;
	localparam int ev_out_bit   = 2;
	localparam int ev_width     = 3;

	// ====================================================================
	// timing
	localparam int clk_hz         = 10_000_000;
	localparam int blink_half_ms  = 500;
	localparam int blink_half_cyc = clk_hz / 1000 * blink_half_ms;
	localparam int link_hold_ms   = 50;
	localparam int link_hold_cyc  = clk_hz / 1000 * link_hold_ms;

	typedef enum logic [2:0] {
		out_correct_locked,
		out_correct_free,
		out_frozen,
		out_errors,
		out_corrupted,
		out_none
	} out_cond_t;

	typedef struct packed {
		logic sdi_present;
		logic sdi_valid;
		logic is_625;
		logic edh_error;
		logic ref_present;
		logic ref_valid;
	} video_status_t;

	typedef struct packed {
		logic fault;
		logic std_525;
		logic std_625;
		logic mode_auto;
		logic filter;
		logic link_activity;
		logic setup_activity;
		logic power_good;
	} leds_t;

endpackage

// *** video_encoder_status_indicator_bench.sv ***
// testbench for status indicator
`timescale 1ns/1ps
`default_nettype none
module video_encoder_status_indicator_bench
	import status_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_fitted, link_event, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [2:0] scene;
	logic err;
	video_status_t vstat;
	leds_t leds;
	out_cond_t out_cond;
	int n_mismatch, check_count;
	status_indicator #(.blink_half_cycles(4), .link_hold_cycles(8)) status_indicator_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.vstat(vstat), .sync_fitted(sync_fitted), .link_event(link_event), .leds(leds),
		.out_cond(out_cond), .irq(irq));
	video_source_model video_source_model_inst (.scene(scene), .vstat(vstat));
	always #50 pclk = ~pclk;
	// ====================================================================
	// tasks
	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		check_count++;
		if ((got & m) !== (exp & m)) begin
			n_mismatch++;
			$display("mismatch at %0t got %h expected %h", $time, got & m, exp & m);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin n_mismatch++; final_report(); end
		rv = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task go(input logic [2:0] s, input logic sf);
		@(posedge pclk);
		scene <= s; sync_fitted <= sf;
		repeat (2) @(posedge pclk);
	endtask
	task st(input logic [2:0] oc, input logic [7:0] l, input logic [7:0] m);
		apb(1'b0, state_off, 32'h0);
		chk(rv, {21'h0, oc, l}, {21'h0, 3'h7, m});
		$display("test done at %0t", $time);
	endtask
	task ck_irq(input logic e);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, e}, 32'h1);
	endtask
	// ====================================================================
	// sequence
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		scene = 0; sync_fitted = 1; link_event = 0; n_mismatch = 0; check_count = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		st(out_correct_locked, 8'h53, 8'hff);
		apb(1'b0, ctrl_off, 0); chk(rv, 32'h21, 32'h3f);
		apb(1'b1, ctrl_off, 32'h1); st(out_correct_locked, 8'h51, 8'hff);
		apb(1'b1, irq_mask_off, 32'h1); apb(1'b0, irq_stat_off, 0); ck_irq(1'b0);
		go(2, 1); st(out_corrupted, 8'h11, 8'h7f); ck_irq(1'b1);
		go(0, 1); apb(1'b0, irq_stat_off, 0); chk(rv, 32'h1, 32'h1); ck_irq(1'b0);
		apb(1'b1, irq_mask_off, 0); apb(1'b1, ctrl_off, 32'h9);
		go(2, 1); st(out_frozen, 8'h11, 8'h7f); ck_irq(1'b0);
		go(2, 0); st(out_none, 8'h11, 8'h7f);
		go(0, 0); st(out_correct_free, 8'h51, 8'hff);
		apb(1'b1, ctrl_off, 32'h1);
		go(3, 1); st(out_errors, 8'h51, 8'h7f);
		go(4, 1); st(out_correct_free, 8'h11, 8'h3f);
		chk({31'h0, rv[7]}, {31'h0, rv[6]}, 32'h1);
		apb(1'b1, ctrl_off, 32'h5);
		go(5, 1); st(out_correct_free, 8'h51, 8'hff);
		go(6, 1); st(out_corrupted, 8'h11, 8'h7f);
		go(6, 0); st(out_corrupted, 8'h11, 8'h7f);
		go(6, 1);
		apb(1'b1, ctrl_off, 32'h0);
		go(1, 1); st(out_corrupted, 8'h01, 8'h3f);
		apb(1'b1, ctrl_off, 32'h11);
		go(0, 1); st(out_correct_locked, 8'h59, 8'hff);
		go(1, 1); st(out_correct_locked, 8'h39, 8'hff);
		apb(1'b1, ctrl_off, 32'h1);
		@(posedge pclk); link_event <= 1'b1;
		@(posedge pclk); link_event <= 1'b0;
		st(out_correct_locked, 8'h35, 8'hff);
		repeat (12) @(posedge pclk);
		st(out_correct_locked, 8'h31, 8'hff);
		apb(1'b0, 12'h010, 0); chk({rv[30:0], err}, 32'h1, 32'hffffffff);
		final_report();
	end
endmodule
`default_nettype wire

// *** video_source_model.sv ***
// video source and reference model driving status levels
`timescale 1ns/1ps
`default_nettype none
module video_source_model
	import status_pkg::*;
(
	// scenario select
	input  wire logic [2:0] scene,
	// status levels
	output video_status_t   vstat
);
	always_comb begin
		case (scene)
			3'h1:    vstat = 6'h3b;
			3'h2:    vstat = 6'h03;
			3'h3:    vstat = 6'h37;
			3'h4:    vstat = 6'h30;
			3'h5:    vstat = 6'h32;
			3'h6:    vstat = 6'h23;
			default: vstat = 6'h33;
		endcase
	end
endmodule
`default_nettype wire
